// file: rtl/acs_pkg.sv
// Purpose: shared constants for the conversion sequencer
// Assumes: byte-wide register port, 200 MHz MCLK
// Notes:   offsets are byte addresses

package acs_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ACS_PWR_OFS   = 8'h64;
    localparam logic [7:0] ACS_RES_LOW   = 8'h78;
    localparam logic [7:0] ACS_RES_HIGH  = 8'h79;
    localparam logic [7:0] ACS_CSA_OFS   = 8'h7A;
    localparam logic [7:0] ACS_CSB_OFS   = 8'h7B;
    localparam logic [7:0] ACS_CHREF_OFS = 8'h7C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ACS_PWR_BIT   = 0;
    localparam int ACS_EN_BIT    = 7;
    localparam int ACS_START_BIT = 6;
    localparam int ACS_AUTO_BIT  = 5;
    localparam int ACS_FLAG_BIT  = 4;
    localparam int ACS_IE_BIT    = 3;
    localparam int ACS_LADJ_BIT  = 5;
    localparam int ACS_REF_LSB   = 6;
    localparam int ACS_CH_LSB    = 0;
    localparam int ACS_TSS_LSB   = 0;

    // ************************************************************
    // reset values and encodings
    // ************************************************************
    localparam logic [9:0] ACS_RESULT_RST = 10'h000;
    localparam logic [7:0] ACS_BYTE_RST   = 8'h00;
    localparam logic [9:0] ACS_DIFF_FLIP  = 10'h200;
    localparam logic [9:0] ACS_MSB_TRIAL  = 10'h200;
    localparam logic [4:0] ACS_DIFF_FIRST = 5'h08;
    localparam logic [2:0] ACS_TSS_FREE   = 3'h0;

    // ************************************************************
    // timing counts in converter clocks and MCLK cycles
    // ************************************************************
    localparam int ACS_PRESC_DIV   = 4;
    localparam int ACS_CONV_CLKS   = 13;
    localparam int ACS_SAMPLE_CLKS = 2;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT,
        ACS_FINISH
    } acs_state_t;

endpackage

// file: rtl/acs_sar_core.sv
// Purpose: prescaled successive-approximation stepping engine
// Assumes: comp_in already synchronised, high when input above trial code
// Notes:   start resets the prescaler; abort drops the conversion silently
`timescale 1ns/1ps

module acs_sar_core
    import acs_pkg::*;
#(
    parameter int PRESC_DIV = ACS_PRESC_DIV,
    parameter int CONV_CLKS = ACS_CONV_CLKS
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       comp_in,
    output logic      [9:0] dac_code,
    output logic            sample,
    output logic            done,
    output logic      [9:0] result
);

    acs_state_t state_reg, state_next;
    logic [7:0] presc_reg, presc_next;
    logic [7:0] step_reg, step_next;
    logic [3:0] bit_reg, bit_next;
    logic [9:0] dac_reg, dac_next;
    logic [9:0] result_reg, result_next;
    logic       sample_reg, sample_next;
    logic       done_reg, done_next;
    logic       tick;
    logic [9:0] trial;

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb
    begin
        state_next  = state_reg;
        step_next   = step_reg;
        bit_next    = bit_reg;
        dac_next    = dac_reg;
        result_next = result_reg;
        sample_next = sample_reg;
        done_next   = 1'b0;
        trial       = dac_reg;
        tick        = (presc_reg == 8'(PRESC_DIV - 1));
        presc_next  = tick ? 8'h00 : presc_reg + 8'h01;
        if (tick && state_reg != ACS_IDLE)
            step_next = step_reg + 8'h01;
        case (state_reg)
            ACS_IDLE:
            begin
                presc_next = 8'h00;
                step_next  = 8'h00;
                if (start)
                begin
                    state_next  = ACS_SAMPLE;
                    sample_next = 1'b1;
                    dac_next    = 10'h000;
                end
            end
            ACS_SAMPLE:
                if (tick && step_reg == 8'(ACS_SAMPLE_CLKS - 1))
                begin
                    state_next  = ACS_CONVERT;
                    sample_next = 1'b0;
                    dac_next    = ACS_MSB_TRIAL;
                    bit_next    = 4'h9;
                end
            ACS_CONVERT:
                if (tick)
                begin
                    if (!comp_in)
                        trial[bit_reg] = 1'b0;
                    if (bit_reg == 4'h0)
                    begin
                        result_next = trial;
                        state_next  = ACS_FINISH;
                    end
                    else
                    begin
                        trial[bit_reg - 4'h1] = 1'b1;
                        bit_next = bit_reg - 4'h1;
                    end
                    dac_next = trial;
                end
            ACS_FINISH:
                if (tick && step_reg == 8'(CONV_CLKS - 1))
                begin
                    state_next = ACS_IDLE;
                    done_next  = 1'b1;
                end
            default:
                state_next = ACS_IDLE;
        endcase
        if (abort)
        begin
            state_next  = ACS_IDLE;
            sample_next = 1'b0;
            done_next   = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg  <= ACS_IDLE;
            presc_reg  <= 8'h00;
            step_reg   <= 8'h00;
            bit_reg    <= 4'h0;
            dac_reg    <= ACS_RESULT_RST;
            result_reg <= ACS_RESULT_RST;
            sample_reg <= 1'b0;
            done_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            presc_reg  <= presc_next;
            step_reg   <= step_next;
            bit_reg    <= bit_next;
            dac_reg    <= dac_next;
            result_reg <= result_next;
            sample_reg <= sample_next;
            done_reg   <= done_next;
        end
    end

    assign dac_code = dac_reg;
    assign sample   = sample_reg;
    assign done     = done_reg;
    assign result   = result_reg;

    done_after_a: assert property (@(posedge clk) disable iff (rst)
        done |-> $past(state_reg) == ACS_FINISH && step_reg == 8'(CONV_CLKS))
        else $error("done without a full conversion");

    sample_first_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ACS_IDLE && start && !abort) |=> sample ##1 sample)
        else $error("sample phase too short");

endmodule

// file: rtl/acs_top.sv
// Purpose: register side and sequencing of a 10-bit converter
// Assumes: trigger sources on MCLK, comparator from the analogue pin
// Notes:   trigger select 0 means free running
//
// Operation
// - 10-bit result, right aligned unless left adjust
// - low byte read locks both result bytes
// - completion while locked discards the new value
// - high byte read unlocks result writes
// - completion always raises the complete flag
// - power on, write start to convert
// - start bit reads one while busy
// - channel change waits for current conversion
// - auto enable with selectable trigger source
// - trigger rising edge restarts prescaler, converts
// - held level or busy edges start nothing
// - flag set regardless of interrupt enables
// - free running change shows two results later
// - differential results in two's complement
// - result bytes at 0x78 and 0x79, reset zero
// - left adjust puts result in bits 15..6
`timescale 1ns/1ps

module acs_top
    import acs_pkg::*;
#(
    parameter int PRESC_DIV = ACS_PRESC_DIV,
    parameter int CONV_CLKS = ACS_CONV_CLKS
)
(
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    output logic      [7:0] RD_DATA,
    input  wire logic [6:0] TRIG_IN,
    input  wire logic       COMP_IN,
    output logic      [9:0] DAC_CODE,
    output logic            SAMPLE_HOLD,
    output logic      [4:0] MUX_SEL,
    output logic      [1:0] REF_SEL,
    output logic            AFE_ENABLE,
    output logic            CONV_FLAG,
    output logic            IRQ
);

    function automatic logic [15:0] acs_align(input logic [9:0] res, input logic ladj);
        acs_align = ladj ? {res, 6'h00} : {6'h00, res};
    endfunction

    logic       comp_meta_reg, comp_sync_reg;
    logic       pwr_reg, pwr_next;
    logic       en_reg, en_next;
    logic       auto_reg, auto_next;
    logic       ie_reg, ie_next;
    logic       flag_reg, flag_next;
    logic [2:0] tss_reg, tss_next;
    logic [1:0] ref_reg, ref_next;
    logic       ladj_reg, ladj_next;
    logic [4:0] chan_reg, chan_next;
    logic       busy_reg, busy_next;
    logic       locked_reg, locked_next;
    logic [9:0] result_reg, result_next;
    logic [4:0] conv_chan_reg, conv_chan_next;
    logic [1:0] conv_ref_reg, conv_ref_next;
    logic       trig_prev_reg, trig_prev_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic       irq_reg, irq_next;
    logic       afe_en_reg, afe_en_next;

    logic       wr_csa, rd_low, rd_high;
    logic       on_now, on_next;
    logic [7:0] trig_vec;
    logic       trig_sel, trig_edge;
    logic       sw_start, auto_start, free_start, start_go, abort;
    logic       core_done;
    logic [9:0] core_result;
    logic [15:0] aligned;

    // ************************************************************
    // comparator synchroniser
    // ************************************************************
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end
        else
        begin
            comp_meta_reg <= COMP_IN;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // ************************************************************
    // registers, start control and result capture
    // ************************************************************
    always_comb
    begin
        wr_csa  = WR_EN && ADDR == ACS_CSA_OFS;
        rd_low  = RD_EN && ADDR == ACS_RES_LOW;
        rd_high = RD_EN && ADDR == ACS_RES_HIGH;

        pwr_next  = pwr_reg;
        en_next   = en_reg;
        auto_next = auto_reg;
        ie_next   = ie_reg;
        tss_next  = tss_reg;
        ref_next  = ref_reg;
        ladj_next = ladj_reg;
        chan_next = chan_reg;
        if (WR_EN && ADDR == ACS_PWR_OFS)
            pwr_next = WR_DATA[ACS_PWR_BIT];
        if (wr_csa)
        begin
            en_next   = WR_DATA[ACS_EN_BIT];
            auto_next = WR_DATA[ACS_AUTO_BIT];
            ie_next   = WR_DATA[ACS_IE_BIT];
        end
        if (WR_EN && ADDR == ACS_CSB_OFS)
            tss_next = WR_DATA[ACS_TSS_LSB +: 3];
        if (WR_EN && ADDR == ACS_CHREF_OFS)
        begin
            ref_next  = WR_DATA[ACS_REF_LSB +: 2];
            ladj_next = WR_DATA[ACS_LADJ_BIT];
            chan_next = WR_DATA[ACS_CH_LSB +: 5];
        end

        on_now  = en_reg && !pwr_reg;
        on_next = en_next && !pwr_next;

        trig_vec       = {TRIG_IN, 1'b0};
        trig_sel       = trig_vec[tss_reg];
        trig_prev_next = trig_sel;
        trig_edge      = trig_sel && !trig_prev_reg;

        sw_start   = wr_csa && WR_DATA[ACS_START_BIT] && on_next && !busy_reg;
        auto_start = auto_reg && on_now && !busy_reg && trig_edge
                     && tss_reg != ACS_TSS_FREE;
        free_start = auto_reg && on_now && core_done && tss_reg == ACS_TSS_FREE;
        start_go   = sw_start || auto_start || free_start;
        abort      = busy_reg && !on_now;

        busy_next = busy_reg;
        if (core_done || abort)
            busy_next = 1'b0;
        if (start_go)
            busy_next = 1'b1;

        conv_chan_next = conv_chan_reg;
        conv_ref_next  = conv_ref_reg;
        if (start_go)
        begin
            conv_chan_next = chan_next;
            conv_ref_next  = ref_next;
        end

        flag_next = flag_reg;
        if (wr_csa && WR_DATA[ACS_FLAG_BIT])
            flag_next = 1'b0;
        if (core_done)
            flag_next = 1'b1;

        locked_next = locked_reg;
        if (rd_low)
            locked_next = 1'b1;
        if (rd_high)
            locked_next = 1'b0;

        result_next = result_reg;
        if (core_done && !locked_reg && !rd_low)
        begin
            if (conv_chan_reg >= ACS_DIFF_FIRST)
                result_next = core_result ^ ACS_DIFF_FLIP;
            else
                result_next = core_result;
        end

        aligned      = acs_align(result_reg, ladj_reg);
        rd_data_next = ACS_BYTE_RST;
        if (RD_EN)
        begin
            case (ADDR)
                ACS_RES_LOW:   rd_data_next = aligned[7:0];
                ACS_RES_HIGH:  rd_data_next = aligned[15:8];
                ACS_CSA_OFS:   rd_data_next = {en_reg, busy_reg, auto_reg, flag_reg,
                                               ie_reg, 3'h0};
                ACS_CSB_OFS:   rd_data_next = {5'h00, tss_reg};
                ACS_CHREF_OFS: rd_data_next = {ref_reg, ladj_reg, chan_reg};
                ACS_PWR_OFS:   rd_data_next = {7'h00, pwr_reg};
                default:       rd_data_next = ACS_BYTE_RST;
            endcase
        end

        irq_next    = flag_next && ie_next;
        afe_en_next = on_next;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            pwr_reg       <= 1'b0;
            en_reg        <= 1'b0;
            auto_reg      <= 1'b0;
            ie_reg        <= 1'b0;
            flag_reg      <= 1'b0;
            tss_reg       <= 3'h0;
            ref_reg       <= 2'h0;
            ladj_reg      <= 1'b0;
            chan_reg      <= 5'h00;
            busy_reg      <= 1'b0;
            locked_reg    <= 1'b0;
            result_reg    <= ACS_RESULT_RST;
            conv_chan_reg <= 5'h00;
            conv_ref_reg  <= 2'h0;
            trig_prev_reg <= 1'b0;
            rd_data_reg   <= ACS_BYTE_RST;
            irq_reg       <= 1'b0;
            afe_en_reg    <= 1'b0;
        end
        else
        begin
            pwr_reg       <= pwr_next;
            en_reg        <= en_next;
            auto_reg      <= auto_next;
            ie_reg        <= ie_next;
            flag_reg      <= flag_next;
            tss_reg       <= tss_next;
            ref_reg       <= ref_next;
            ladj_reg      <= ladj_next;
            chan_reg      <= chan_next;
            busy_reg      <= busy_next;
            locked_reg    <= locked_next;
            result_reg    <= result_next;
            conv_chan_reg <= conv_chan_next;
            conv_ref_reg  <= conv_ref_next;
            trig_prev_reg <= trig_prev_next;
            rd_data_reg   <= rd_data_next;
            irq_reg       <= irq_next;
            afe_en_reg    <= afe_en_next;
        end
    end

    // ************************************************************
    // conversion engine
    // ************************************************************
    acs_sar_core #(
        .PRESC_DIV (PRESC_DIV),
        .CONV_CLKS (CONV_CLKS)
    ) u_core (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .start    (start_go),
        .abort    (abort),
        .comp_in  (comp_sync_reg),
        .dac_code (DAC_CODE),
        .sample   (SAMPLE_HOLD),
        .done     (core_done),
        .result   (core_result)
    );

    assign RD_DATA    = rd_data_reg;
    assign MUX_SEL    = conv_chan_reg;
    assign REF_SEL    = conv_ref_reg;
    assign AFE_ENABLE = afe_en_reg;
    assign CONV_FLAG  = flag_reg;
    assign IRQ        = irq_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_low_read;
        rd_low;
    endsequence

    sequence s_done_locked;
        core_done && locked_reg && !rd_high;
    endsequence

    lock_set_a: assert property (s_low_read |=> locked_reg)
        else $error("low byte read did not lock");

    lock_keep_a: assert property (s_done_locked |=> $stable(result_reg))
        else $error("locked result overwritten");

    unlock_a: assert property (rd_high |=> !locked_reg)
        else $error("high byte read did not unlock");

    flag_done_a: assert property (core_done |=> flag_reg && (irq_reg == ie_reg))
        else $error("flag not set on completion");

    busy_read_a: assert property ((RD_EN && ADDR == ACS_CSA_OFS && busy_reg)
        |=> RD_DATA[ACS_START_BIT])
        else $error("start bit low while busy");

    busy_clear_a: assert property ((core_done && !start_go) |=> !busy_reg)
        else $error("start bit not cleared at completion");

    chan_hold_a: assert property ((busy_reg && !core_done) |=> $stable(MUX_SEL))
        else $error("channel changed mid conversion");

    trig_start_a: assert property (auto_start |=> busy_reg ##1 SAMPLE_HOLD)
        else $error("trigger edge did not start");

    trig_ignore_a: assert property (start_go |-> (!busy_reg || core_done))
        else $error("start taken during conversion");

    left_zero_a: assert property ((rd_low && ladj_reg) |=> RD_DATA[5:0] == 6'h00)
        else $error("left adjusted low bits not zero");

    right_high_a: assert property ((rd_high && !ladj_reg) |=> RD_DATA[7:2] == 6'h00)
        else $error("right adjusted high bits not zero");

endmodule

// file: tb/acs_afe_model.sv
// Purpose: analogue front end seen by the sequencer
// Assumes: input level is base_code plus channel, half an LSB above that code
// Notes:   comparator output churns while the front end is powered down
`timescale 1ns/1ps

module acs_afe_model
    import acs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [9:0] base_code,
    input  wire logic [9:0] dac_code,
    input  wire logic       sample_hold,
    input  wire logic [4:0] mux_sel,
    input  wire logic       afe_enable,
    output logic            comp_out
);
    logic [9:0] held;
    logic       churn;

    initial
    begin
        held  = 10'h000;
        churn = 1'b0;
    end

    // track while sampling, hold afterwards
    always @(posedge clk)
    begin
        if (sample_hold)
            held <= base_code + {5'h00, mux_sel};
        churn <= ~churn;
    end

    assign comp_out = afe_enable ? (held >= dac_code) : churn;
endmodule

// file: tb/test_adc_conversion_sequencer.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: front end model answers with base_code plus channel
// Notes:   register traffic only through wr and rd
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %0t value differs", $time); end end

module test_adc_conversion_sequencer
    import acs_pkg::*;
;
    logic       MCLK, SYS_RST, WR_EN, RD_EN, COMP_IN, SAMPLE_HOLD;
    logic       AFE_ENABLE, CONV_FLAG, IRQ;
    logic [7:0] ADDR, WR_DATA, RD_DATA, d;
    logic [6:0] TRIG_IN;
    logic [9:0] DAC_CODE, base_code, e;
    logic [4:0] MUX_SEL;
    logic [1:0] REF_SEL;
    int         failures, checks_done;

    acs_top #(.PRESC_DIV(4), .CONV_CLKS(13)) dut (.MCLK(MCLK), .SYS_RST(SYS_RST),
        .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .RD_DATA(RD_DATA), .TRIG_IN(TRIG_IN), .COMP_IN(COMP_IN),
        .DAC_CODE(DAC_CODE), .SAMPLE_HOLD(SAMPLE_HOLD), .MUX_SEL(MUX_SEL),
        .REF_SEL(REF_SEL), .AFE_ENABLE(AFE_ENABLE), .CONV_FLAG(CONV_FLAG), .IRQ(IRQ));

    acs_afe_model afe (.clk(MCLK), .base_code(base_code), .dac_code(DAC_CODE),
        .sample_hold(SAMPLE_HOLD), .mux_sel(MUX_SEL), .afe_enable(AFE_ENABLE),
        .comp_out(COMP_IN));

    initial
    begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    // ********************
    // bus and helper tasks
    // ********************
    task automatic tally_and_finish;
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge MCLK);
        ADDR    <= a;
        WR_DATA <= v;
        WR_EN   <= 1'b1;
        @(posedge MCLK);
        WR_EN   <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge MCLK);
        ADDR  <= a;
        RD_EN <= 1'b1;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1 v = RD_DATA;
        @(posedge MCLK);
    endtask

    task automatic wait_flag;
        int n;
        n = 0;
        while (CONV_FLAG !== 1'b1 && n < 300)
        begin
            @(posedge MCLK);
            #1 n++;
        end
        if (CONV_FLAG !== 1'b1)
        begin
            failures++;
            tally_and_finish();
        end
    endtask

    function automatic logic [9:0] lvl(input logic [4:0] ch);
        lvl = base_code + {5'h00, ch};
        if (ch >= ACS_DIFF_FIRST)
            lvl = lvl ^ ACS_DIFF_FLIP;
    endfunction

    task automatic chk_res(input logic [9:0] x);
        logic [7:0] l;
        logic [7:0] h;
        rd(ACS_RES_LOW, l);
        rd(ACS_RES_HIGH, h);
        `CHK({h, l}, {6'h00, x})
    endtask

    task automatic convert(input logic [7:0] chref);
        wr(ACS_CHREF_OFS, chref);
        wr(ACS_CSA_OFS, 8'hC0);
        wait_flag();
        wr(ACS_CSA_OFS, 8'h90);
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_reset;
        rd(ACS_RES_LOW, d);
        `CHK(d, 8'h00)
        rd(ACS_RES_HIGH, d);
        `CHK(d, 8'h00)
        rd(8'h50, d);
        `CHK(d, 8'h00)
    endtask

    task automatic t_single;
        wr(ACS_PWR_OFS, 8'h00);
        wr(ACS_CHREF_OFS, 8'h43);
        wr(ACS_CSA_OFS, 8'hC8);
        rd(ACS_CSA_OFS, d);
        `CHK(d[ACS_START_BIT], 1'b1)
        `CHK(MUX_SEL, 5'h03)
        `CHK(REF_SEL, 2'h1)
        wait_flag();
        @(posedge MCLK);
        #1 `CHK(IRQ, 1'b1)
        rd(ACS_CSA_OFS, d);
        `CHK(d[ACS_START_BIT], 1'b0)
        wr(ACS_CSA_OFS, 8'h90);
        @(posedge MCLK);
        #1 `CHK(CONV_FLAG, 1'b0)
        `CHK(IRQ, 1'b0)
        chk_res(lvl(5'h03));
    endtask

    task automatic t_left;
        e = lvl(5'h03);
        wr(ACS_CHREF_OFS, 8'h23);
        rd(ACS_RES_LOW, d);
        `CHK(d, {e[1:0], 6'h00})
        rd(ACS_RES_HIGH, d);
        `CHK(d, e[9:2])
        wr(ACS_CHREF_OFS, 8'h03);
    endtask

    task automatic t_lock;
        e = lvl(5'h03);
        rd(ACS_RES_LOW, d);
        base_code = 10'h0A0;
        convert(8'h03);
        rd(ACS_RES_HIGH, d);
        `CHK(d, {6'h00, e[9:8]})
        rd(ACS_RES_LOW, d);
        `CHK(d, e[7:0])
        rd(ACS_RES_HIGH, d);
        convert(8'h03);
        chk_res(lvl(5'h03));
    endtask

    task automatic t_chan;
        wr(ACS_CHREF_OFS, 8'h02);
        wr(ACS_CSA_OFS, 8'hC0);
        repeat (10) @(posedge MCLK);
        wr(ACS_CHREF_OFS, 8'h05);
        #1 `CHK(MUX_SEL, 5'h02)
        wait_flag();
        wr(ACS_CSA_OFS, 8'h90);
        chk_res(lvl(5'h02));
        convert(8'h05);
        chk_res(lvl(5'h05));
    endtask

    task automatic t_diff;
        logic [4:0] chs[3] = '{5'h07, 5'h08, 5'h1F};
        foreach (chs[i])
        begin
            if (chs[i] >= ACS_DIFF_FIRST)
            begin
                wr(ACS_CHREF_OFS, {3'h0, chs[i]});
                repeat (25000) @(posedge MCLK);
            end
            convert({3'h0, chs[i]});
            chk_res(lvl(chs[i]));
        end
    endtask

    task automatic t_power;
        wr(ACS_PWR_OFS, 8'h01);
        wr(ACS_CSA_OFS, 8'hC0);
        rd(ACS_CSA_OFS, d);
        `CHK(d[ACS_START_BIT], 1'b0)
        `CHK(AFE_ENABLE, 1'b0)
        wr(ACS_PWR_OFS, 8'h00);
        @(posedge MCLK);
        #1 `CHK(AFE_ENABLE, 1'b1)
    endtask

    task automatic t_trig;
        logic [6:0] others;
        @(posedge MCLK);
        for (int k = 1; k <= 7; k++)
        begin
            others = ~(7'h01 << (k - 1));
            TRIG_IN <= 7'h00;
            wr(ACS_CSB_OFS, 8'(k));
            wr(ACS_CSA_OFS, 8'hA0);
            TRIG_IN <= others;
            repeat (3) @(posedge MCLK);
            rd(ACS_CSA_OFS, d);
            `CHK(d[ACS_START_BIT], 1'b0)
            TRIG_IN <= 7'h7F;
            repeat (3) @(posedge MCLK);
            rd(ACS_CSA_OFS, d);
            `CHK(d[ACS_START_BIT], 1'b1)
            TRIG_IN <= others;
            @(posedge MCLK);
            TRIG_IN <= 7'h7F;
            wait_flag();
            repeat (20) @(posedge MCLK);
            rd(ACS_CSA_OFS, d);
            `CHK(d[ACS_START_BIT], 1'b0)
            wr(ACS_CSA_OFS, 8'hB0);
        end
        TRIG_IN <= 7'h00;
        wr(ACS_CSA_OFS, 8'h80);
    endtask

    task automatic t_free;
        base_code = 10'h100;
        wr(ACS_CSB_OFS, 8'h00);
        wr(ACS_CHREF_OFS, 8'h01);
        wr(ACS_CSA_OFS, 8'hE0);
        wait_flag();
        wr(ACS_CHREF_OFS, 8'h06);
        wr(ACS_CSA_OFS, 8'hF0);
        chk_res(lvl(5'h01));
        wait_flag();
        wr(ACS_CSA_OFS, 8'hF0);
        chk_res(lvl(5'h01));
        wait_flag();
        wr(ACS_CSA_OFS, 8'hF0);
        chk_res(lvl(5'h06));
        wr(ACS_CSA_OFS, 8'h10);
    endtask

    initial
    begin
        ADDR        = 8'h00;
        WR_DATA     = 8'h00;
        WR_EN       = 1'b0;
        RD_EN       = 1'b0;
        TRIG_IN     = 7'h00;
        base_code   = 10'h155;
        failures    = 0;
        checks_done = 0;
        SYS_RST     = 1'b1;
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_single();
        t_left();
        t_lock();
        t_chan();
        t_diff();
        t_power();
        t_trig();
        t_free();
        tally_and_finish();
    end
endmodule
